// >>> hdl/flag_exec_defines.svh
// Constants of the flag branch and bit clear execution block.
// Offsets, field positions, reset values, opcodes and phase counts.
`ifndef FLAG_EXEC_DEFINES_SVH
`define FLAG_EXEC_DEFINES_SVH

// Register byte offsets on the APB
`define OFF_INSTR      8'h00
`define OFF_ACC        8'h04
`define OFF_FLAGS      8'h08
`define OFF_BANK       8'h0c
`define OFF_PC         8'h10
`define OFF_EXST       8'h14
`define OFF_FADDR      8'h18
`define OFF_FDATA      8'h1c

// Flag positions in the flags register
`define FLG_C          0
`define FLG_Z          2
`define FLG_N          4

// Execution status fields
`define EXST_BUSY      0
`define EXST_TAKEN     1
`define EXST_CYC_LO    2

// Instruction fields
`define OPC_BR_CARRY   8'he2
`define OPC_BR_NEG     8'he6
`define OPC_CLRBIT     4'h9
`define OPC_AND_ACCUMULATOR_WITH_FILE      6'h05
`define IW_BIT_HI      11
`define IW_BIT_LO      9
`define IW_DEST        9
`define IW_BANKSEL     8

// Widths and reset values
`define PC_W           21
`define FA_W           12
`define RST_PC         21'h000000
`define RST_ACC        8'h00
`define RST_FLAGS      8'h00
`define RST_BANK       4'h0
`define ACCESS_BANK    4'h0

// Phases per instruction cycle, one CLK each
`define PHASE_LAST     2'h3
`define CYC_ONE        2'h1
`define CYC_TWO        2'h2

`endif

// >>> hdl/flag_exec_pkg.sv
// Types shared by the execution block and its helpers.
// Assumes the defines header is on the include path.
`include "flag_exec_defines.svh"

package flag_exec_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b11
  } exec_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BC   = 3'h1,
    OP_BN   = 3'h2,
    OP_CLR  = 3'h3,
    OP_AND  = 3'h4
  } op_kind_t;

  typedef struct packed {
    logic               we;
    logic [`FA_W-1:0]   addr;
    logic [7:0]         wdata;
  } ram_req_t;

  typedef struct packed {
    exec_state_t        state;
    logic               busy;
    logic               ready;
    logic               slverr;
    logic [31:0]        prdata;
    logic [15:0]        instr;
    op_kind_t           op;
    logic [`PC_W-1:0]   pc;
    logic [7:0]         w;
    logic [7:0]         flags;
    logic [3:0]         bank_select_register;
    logic [`FA_W-1:0]   faddr;
    logic [`FA_W-1:0]   xaddr;
    logic [7:0]         data;
    logic [7:0]         result;
    logic [`PC_W-1:0]   target;
    logic               taken;
    logic [1:0]         cycles;
  } core_st_t;

  typedef struct packed {
    logic [1:0]         cnt;
  } phase_st_t;

endpackage : flag_exec_pkg

// >>> hdl/phase_gen.sv
// Four-phase sequencer of one instruction cycle.
// Assumes one CLK per phase; holds phase zero while not running.
`timescale 1ns/1ps
`default_nettype none
`include "flag_exec_defines.svh"

module phase_gen
  import flag_exec_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       run,
  // Phase
  output logic [1:0]      phase,
  output logic            last
);

  phase_st_t s_q;
  phase_st_t s_d;

  always_comb begin
    s_d.cnt = run ? 2'(s_q.cnt + 2'h1) : 2'h0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.cnt;
  assign last  = (s_q.cnt == `PHASE_LAST);

endmodule : phase_gen
`default_nettype wire

// >>> hdl/file_ram.sv
// Banked data memory of file registers.
// Assumes one requester at a time; read is combinational, write on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "flag_exec_defines.svh"

module file_ram
  import flag_exec_pkg::*;
#(
  parameter int DEPTH = 4096
)
(
  // Clock
  input  wire logic       clk,
  // Access
  input  wire ram_req_t   req,
  output logic [7:0]      rdata
);

  // No reset: contents are undefined until software writes them
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  assign rdata = mem[req.addr];

endmodule : file_ram
`default_nettype wire

// >>> hdl/flag_exec.sv
// Execution of branch on carry, branch on negative, bit clear of a file
// register and the accumulator AND with file, one instruction at a time.
// Assumes an APB master writes the instruction word; CLK is one phase.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "flag_exec_defines.svh"

module flag_exec
  import flag_exec_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Core status
  output logic             BUSY
);

  localparam core_st_t RST_ST = '{
    state:  ST_IDLE,
    op:     OP_NONE,
    pc:     `RST_PC,
    w:      `RST_ACC,
    flags:  `RST_FLAGS,
    bank_select_register:    `RST_BANK,
    default: '0
  };

  core_st_t    s_q;
  core_st_t    s_d;
  logic [1:0]  phase;
  logic        phase_last;
  logic        run;
  ram_req_t    ram_req;
  logic [7:0]  ram_rdata;
  logic        prep;
  logic        commit;
  logic        mapped;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  assign run = (s_q.state != ST_IDLE);

  phase_gen u_phase (
    .clk   (CLK),
    .srst  (SRST),
    .run   (run),
    .phase (phase),
    .last  (phase_last)
  );

  file_ram u_ram (
    .clk   (CLK),
    .req   (ram_req),
    .rdata (ram_rdata)
  );

  function automatic op_kind_t decode(input logic [15:0] iw);
    op_kind_t k;
    k = OP_NONE;
    if (iw[15:8] == `OPC_BR_CARRY) begin
      k = OP_BC;
    end else if (iw[15:8] == `OPC_BR_NEG) begin
      k = OP_BN;
    end else if (iw[15:12] == `OPC_CLRBIT) begin
      k = OP_CLR;
    end else if (iw[15:10] == `OPC_AND_ACCUMULATOR_WITH_FILE) begin
      k = OP_AND;
    end
    return k;
  endfunction : decode

  //////////////////////////////////////////////////////////////////////
  // APB decode

  // One wait state: PREADY comes from a flop set in the first access cycle
  assign prep   = PSEL & PENABLE & ~s_q.ready;
  assign commit = PSEL & PENABLE & s_q.ready & PWRITE & ~s_q.slverr;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `OFF_INSTR: rd_mux = {16'h0000, s_q.instr};
      `OFF_ACC:   rd_mux = {24'h00_0000, s_q.w};
      `OFF_FLAGS: rd_mux = {24'h00_0000, s_q.flags};
      `OFF_BANK:  rd_mux = {28'h000_0000, s_q.bank_select_register};
      `OFF_PC:    rd_mux = {11'h000, s_q.pc};
      `OFF_EXST: begin
        rd_mux[`EXST_BUSY]                = s_q.busy;
        rd_mux[`EXST_TAKEN]               = s_q.taken;
        rd_mux[`EXST_CYC_LO+1:`EXST_CYC_LO] = s_q.cycles;
      end
      `OFF_FADDR: rd_mux = {20'h0_0000, s_q.faddr};
      `OFF_FDATA: rd_mux = {24'h00_0000, ram_rdata};
      default:    mapped = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Memory port

  // The executing instruction owns the memory port while busy
  always_comb begin
    ram_req = '0;
    if (run) begin
      ram_req.addr  = s_q.xaddr;
      ram_req.wdata = s_q.result;
      ram_req.we    = (s_q.state == ST_EXEC) && phase_last &&
                      ((s_q.op == OP_CLR) ||
                       (s_q.op == OP_AND && s_q.instr[`IW_DEST]));
    end else begin
      ram_req.addr  = s_q.faddr;
      ram_req.wdata = PWDATA[7:0];
      ram_req.we    = commit && (PADDR == `OFF_FDATA);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;

    // Bus answer
    s_d.ready = prep;
    if (prep) begin
      s_d.prdata = mapped ? rd_mux : 32'h0000_0000;
      // Writes while busy are refused so state never changes mid-instruction
      s_d.slverr = ~mapped | (PWRITE & s_q.busy) |
                   (PADDR == `OFF_FDATA & s_q.busy);
    end

    // Register writes, only ever while idle
    if (commit) begin
      case (PADDR)
        `OFF_INSTR: begin
          s_d.instr = PWDATA[15:0];
          s_d.state = ST_EXEC;
          s_d.busy  = 1'b1;
        end
        `OFF_ACC:   s_d.w     = PWDATA[7:0];
        `OFF_FLAGS: s_d.flags = PWDATA[7:0];
        `OFF_BANK:  s_d.bank_select_register   = PWDATA[3:0];
        `OFF_PC:    s_d.pc    = PWDATA[`PC_W-1:0];
        `OFF_FADDR: s_d.faddr = PWDATA[`FA_W-1:0];
        default:    s_d.busy  = s_q.busy;
      endcase
    end

    case (s_q.state)
      ST_IDLE: begin
        s_d.busy = s_d.busy;
      end
      ST_EXEC: begin
        case (phase)
          2'h0: begin
            // Decode; the fetch increments the PC here
            s_d.op = decode(s_q.instr);
            s_d.pc = `PC_W'(s_q.pc + `PC_W'(2));
            if (s_q.instr[`IW_BANKSEL]) begin
              s_d.xaddr = {s_q.bank_select_register, s_q.instr[7:0]};
            end else begin
              s_d.xaddr = {`ACCESS_BANK, s_q.instr[7:0]};
            end
          end
          2'h1: begin
            // Offset literal for branches, file register otherwise
            if (s_q.op == OP_BC || s_q.op == OP_BN) begin
              s_d.data = s_q.instr[7:0];
            end else begin
              s_d.data = ram_rdata;
            end
          end
          2'h2: begin
            // Sign extended offset, doubled
            s_d.target = `PC_W'(s_q.pc +
                         {{(`PC_W-9){s_q.data[7]}}, s_q.data, 1'b0});
            s_d.taken  = ((s_q.op == OP_BC) && s_q.flags[`FLG_C]) ||
                         ((s_q.op == OP_BN) && s_q.flags[`FLG_N]);
            if (s_q.op == OP_CLR) begin
              s_d.result = s_q.data &
                           ~(8'h01 << s_q.instr[`IW_BIT_HI:`IW_BIT_LO]);
            end else begin
              s_d.result = s_q.w & s_q.data;
            end
          end
          default: begin
            if (s_q.taken) begin
              s_d.pc     = s_q.target;
              s_d.state  = ST_FLUSH;
              s_d.cycles = `CYC_TWO;
            end else begin
              // Untaken: no PC write in the last phase
              s_d.state  = ST_IDLE;
              s_d.busy   = 1'b0;
              s_d.cycles = `CYC_ONE;
            end
            if (s_q.op == OP_AND) begin
              if (!s_q.instr[`IW_DEST]) begin
                s_d.w = s_q.result;
              end
              s_d.flags[`FLG_Z] = (s_q.result == 8'h00);
              s_d.flags[`FLG_N] = s_q.result[7];
            end
          end
        endcase
      end
      ST_FLUSH: begin
        // Second cycle of a taken branch does nothing
        if (phase_last) begin
          s_d.state = ST_IDLE;
          s_d.busy  = 1'b0;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
        s_d.busy  = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_q <= RST_ST;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA  = s_q.prdata;
  assign PREADY  = s_q.ready;
  assign PSLVERR = s_q.slverr;
  assign BUSY    = s_q.busy;

endmodule : flag_exec
`default_nettype wire

// >>> verif/flag_exec_checker.sv
// Checker of APB timing and instruction run length of flag_exec.
// Assumes it is bound to the top module ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "flag_exec_defines.svh"

module flag_exec_checker
  import flag_exec_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Status
  input wire logic        BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic done;
  logic start;
  assign done  = PSEL && PENABLE && PREADY;
  assign start = done && PWRITE && PADDR == `OFF_INSTR && !BUSY;
  sequence one_cyc;
    BUSY [*4] ##1 !BUSY;
  endsequence
  sequence two_cyc;
    BUSY [*8] ##1 !BUSY;
  endsequence
  ////////////////////////////////////////
  a_ready_late: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY)
    else $error("access phase length wrong");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_idle_quiet: assert property (!PSEL |-> !PREADY)
    else $error("ready without select");
  a_start_busy: assert property (start |=> BUSY)
    else $error("busy did not rise");
  a_branch_len: assert property (start && PWDATA[15:8] inside {`OPC_BR_CARRY, `OPC_BR_NEG}
    |=> one_cyc or two_cyc)
    else $error("branch length wrong");
  a_single_len: assert property (start && (PWDATA[15:12] == `OPC_CLRBIT ||
    PWDATA[15:10] == `OPC_AND_ACCUMULATOR_WITH_FILE) |=> one_cyc)
    else $error("one cycle op length wrong");
  a_busy_cause: assert property (!BUSY && !start |=> !BUSY)
    else $error("busy without instruction");
  a_busy_refuse: assert property (done && PWRITE && BUSY |-> PSLVERR)
    else $error("write while busy accepted");
  a_unmapped_err: assert property (done && PADDR > `OFF_FDATA |-> PSLVERR)
    else $error("unmapped access accepted");
  a_read_ok: assert property (done && !PWRITE && PADDR <= `OFF_FADDR |-> !PSLVERR)
    else $error("plain read refused");
  a_reset_vals: assert property ($past(SRST) |-> !BUSY && !PREADY && PRDATA == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : flag_exec_checker
`default_nettype wire

// >>> verif/flag_exec_tb_top.sv
// Self-checking bench of flag_exec, driven over APB.
// Assumes the package and defines header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "flag_exec_defines.svh"

module flag_exec_tb_top import flag_exec_pkg::*;;
  typedef struct {logic chk; logic err; logic [31:0] exp;} note_t;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  note_t       notes[$];
  int          fails, check_count;

  flag_exec u_dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUSY(busy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Note is queued first; the monitor pops it at completion
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic chk, input logic err, input logic [31:0] exp);
    int n;
    n = 0;
    notes.push_back('{chk, err, exp});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, 1'b0, err, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, !err, err, exp);
  endtask : rd

  // First edge skipped: busy lands one edge after the write
  task automatic run(input logic [15:0] iw);
    int n;
    n = 0;
    wr(`OFF_INSTR, {16'h0, iw});
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 40);
  endtask : run

  always @(posedge clk) begin
    note_t nt;
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      check_count++;
      if (pslverr !== nt.err || (nt.chk && prdata !== nt.exp)) begin
        fails++;
        $display("CHECK FAILED %0t: addr %h data %h err %b", $time, paddr, prdata, pslverr);
      end
    end
  end

  initial begin
    #1000000;
    fails++;
    stop_test();
  end
  ////////////////////////////////////////
  initial begin
    logic [20:0] pc, tgt;
    logic [7:0]  op, off, fl, acc, m, m2, r, f;
    logic [3:0]  bk;
    logic        t, tk, a;
    logic [7:0]  regs [5];
    regs = '{`OFF_ACC, `OFF_FLAGS, `OFF_BANK, `OFF_PC, `OFF_FADDR};
    fails = 0;
    check_count = 0;
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    void'($urandom(36));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 32'h0);
    rd(8'h20, 32'h0, 1'b1);
    wr(8'h24, 32'h1, 1'b1);
    // Third opcode is a neighbour that must not branch
    for (int k = 0; k < 24; k++) begin
      op  = (k % 3 == 0) ? `OPC_BR_CARRY : (k % 3 == 1) ? `OPC_BR_NEG : 8'he3;
      t   = k[0];
      off = (k < 6) ? 8'h80 : (k < 12) ? 8'h7f : 8'($urandom);
      fl  = 8'($urandom) & 8'h15;
      if (op == `OPC_BR_NEG) fl[`FLG_N] = t;
      else fl[`FLG_C] = t;
      pc  = 21'($urandom) & 21'h1ffffe;
      tk  = t && op != 8'he3;
      tgt = pc + 21'd2 + (tk ? {{12{off[7]}}, off, 1'b0} : 21'd0);
      wr(`OFF_PC, 32'(pc));
      wr(`OFF_FLAGS, 32'(fl));
      run({op, off});
      rd(`OFF_PC, 32'(tgt));
      rd(`OFF_FLAGS, 32'(fl));
      rd(`OFF_EXST, tk ? 32'h0a : 32'h04);
    end
    for (int b = 0; b < 8; b++) begin
      bk = 4'($urandom % 15 + 1);
      f  = 8'($urandom);
      m  = 8'($urandom) | (8'h1 << b);
      m2 = 8'($urandom) | (8'h1 << b);
      a  = b[0];
      fl = 8'($urandom) & 8'h15;
      wr(`OFF_BANK, 32'(bk));
      wr(`OFF_FLAGS, 32'(fl));
      wr(`OFF_FADDR, {20'h0, bk, f});
      wr(`OFF_FDATA, 32'(m));
      wr(`OFF_FADDR, {20'h0, `ACCESS_BANK, f});
      wr(`OFF_FDATA, 32'(m2));
      run({`OPC_CLRBIT, 3'(b), a, f});
      rd(`OFF_FDATA, 32'(a ? m2 : m2 & ~(8'h1 << b)));
      wr(`OFF_FADDR, {20'h0, bk, f});
      rd(`OFF_FDATA, 32'(a ? m & ~(8'h1 << b) : m));
      rd(`OFF_FLAGS, 32'(fl));
      rd(`OFF_EXST, 32'h04);
    end
    // First pass forces a zero result
    for (int d = 0; d < 2; d++) begin
      acc = 8'($urandom);
      m   = d ? 8'($urandom) : ~acc;
      r   = acc & m;
      f   = 8'($urandom);
      a   = !d[0];
      wr(`OFF_ACC, 32'(acc));
      wr(`OFF_FLAGS, 32'h01);
      wr(`OFF_FADDR, {20'h0, a ? bk : `ACCESS_BANK, f});
      wr(`OFF_FDATA, 32'(m));
      run({`OPC_AND_ACCUMULATOR_WITH_FILE, d[0], a, f});
      rd(`OFF_ACC, 32'(d ? acc : r));
      rd(`OFF_FDATA, 32'(d ? r : m));
      rd(`OFF_FLAGS, {27'h0, r[7], 1'b0, r == 8'h0, 1'b0, 1'b1});
    end
    // Accesses refused while a taken branch runs
    wr(`OFF_ACC, 32'h5a);
    wr(`OFF_PC, 32'h100);
    wr(`OFF_FLAGS, 32'h01);
    wr(`OFF_INSTR, 32'he2fe);
    rd(`OFF_FDATA, 32'h0, 1'b1);
    wr(`OFF_ACC, 32'ha5, 1'b1);
    run(16'h0000);
    rd(`OFF_ACC, 32'h5a);
    rd(`OFF_PC, 32'h100);
    wr(`OFF_INSTR, 32'he2fe);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`OFF_PC, 32'h0);
    stop_test();
  end
endmodule : flag_exec_tb_top

bind flag_exec flag_exec_checker u_chk (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .BUSY);
`default_nettype wire
